// >>> common/chgctl_irq_if.sv
// chgctl_irq_if: event strobes from the charge control to the interrupt pulser
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
interface chgctl_irq_if;
  logic event_stb;
  logic busy;
  modport src (output event_stb, input busy);
  modport dst (input event_stb, output busy);
endinterface : chgctl_irq_if

// >>> common/chgctl_pkg.sv
// chgctl_pkg: shared constants and types of the charger mode and charge-cycle control
// assumes a 125 MHz mclk; analog comparisons arrive as digital flags
package chgctl_pkg;

  // ------------------------------------------------------------
  // clock and times
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned OTG_WAIT_MS    = 30;
  localparam int unsigned OTG_WAIT_CYC   = OTG_WAIT_MS * CLK_MHZ * 1000;
  localparam int unsigned BLINK_MS       = 1000;
  localparam int unsigned BLINK_CYC      = BLINK_MS * CLK_MHZ * 1000;
  localparam int unsigned INT_PULSE_US   = 256;
  localparam int unsigned INT_PULSE_CYC  = INT_PULSE_US * CLK_MHZ;
  localparam int unsigned WD_UNIT_S      = 40;
  localparam int unsigned WD_UNIT_CYC    = 32'd125_000_000;

  // ------------------------------------------------------------
  // field codes
  // ------------------------------------------------------------
  localparam logic [1:0] PHASE_OFF   = 2'h0;
  localparam logic [1:0] PHASE_PRE   = 2'h1;
  localparam logic [1:0] PHASE_FAST  = 2'h2;
  localparam logic [1:0] PHASE_DONE  = 2'h3;
  localparam logic [2:0] SRC_BOOST   = 3'h7;
  localparam logic [1:0] MON_OVRD    = 2'h1;
  localparam logic [1:0] MON_OFF     = 2'h3;
  localparam logic [1:0] OVR_OFF     = 2'h0;
  localparam logic [1:0] OVR_LOW     = 2'h1;
  localparam logic [1:0] OVR_BLINK11 = 2'h2;
  localparam logic [1:0] OVR_BLINK13 = 2'h3;

  // ------------------------------------------------------------
  // levels in mV / mA
  // ------------------------------------------------------------
  localparam logic [12:0] TRACK_OFS0_MV = 13'd200;
  localparam logic [12:0] TRACK_OFS1_MV = 13'd250;
  localparam logic [12:0] TRACK_OFS2_MV = 13'd300;
  localparam logic [12:0] SYS_LOW_MV    = 13'd2200;
  localparam logic [12:0] SHORT_BAT_MV  = 13'd2200;
  localparam logic [12:0] PRE_BAT_MV    = 13'd3150;
  localparam logic [12:0] RECHG0_MV     = 13'd100;
  localparam logic [12:0] RECHG1_MV     = 13'd200;
  localparam logic [12:0] STARTUP_MA    = 13'd200;
  localparam logic [12:0] BOOST_LO_MA   = 13'd500;
  localparam logic [12:0] BOOST_HI_MA   = 13'd1200;

  // ------------------------------------------------------------
  // defaults used in default mode and after expiry
  // ------------------------------------------------------------
  localparam logic [12:0] DEF_VREG_MV   = 13'd4208;
  localparam logic [12:0] DEF_FAST_CHARGE_CURRENT_MA   = 13'd2040;
  localparam logic [12:0] DEF_IPRE_MA   = 13'd180;
  localparam logic [12:0] DEF_ITERM_MA  = 13'd180;
  localparam logic [12:0] DEF_ISHORT_MA = 13'd90;
  localparam logic [4:0]  DEF_SAFETY_H  = 5'd16;
  localparam logic [1:0]  DEF_WD_SEL    = 2'h1;

  typedef enum logic [1:0] {CHGCTL_IDLE, CHGCTL_RUN, CHGCTL_TOPOFF, CHGCTL_DONE} chgctl_phase_t;

  // host-programmable settings that default mode overrides
  typedef struct packed {
    logic [12:0] vreg_mv;
    logic [12:0] fast_charge_current_ma;
    logic [12:0] ipre_ma;
    logic [12:0] iterm_ma;
    logic [1:0]  track_sel;
    logic        rechg_sel;
    logic        term_en;
    logic        chg_en;
    logic        pskip_dis;
    logic        otg_en;
    logic        boost_hi;
    logic [1:0]  mon_sel;
    logic [1:0]  ovr_sel;
    logic [1:0]  wd_sel;
  } chgctl_cfg_t;

endpackage : chgctl_pkg

// >>> rtl/chgctl_irq_pulse.sv
// chgctl_irq_pulse: turns event strobes into fixed-width active-low pulses
// assumes strobes are single cycles on mclk; events during a pulse are queued as one
`timescale 1ns/1ns
module chgctl_irq_pulse
  import chgctl_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   rst,
  chgctl_irq_if.dst   irq,
  output logic        host_interrupt_n
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        pend;
    logic        out_n;
  } chgctl_irqst_t;

  chgctl_irqst_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (irq.event_stb) begin
      s_nxt.pend = 1'b1;
    end
    if (s_r.cnt != 32'd0) begin
      s_nxt.cnt = s_r.cnt - 32'd1;
      if (s_r.cnt == 32'd1) begin
        s_nxt.out_n = 1'b1;
      end
    end else if (s_r.pend && s_r.out_n) begin
      // gap of one high cycle keeps back-to-back events distinct
      s_nxt.pend  = irq.event_stb;
      s_nxt.out_n = 1'b0;
      s_nxt.cnt   = INT_PULSE_CYC;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '{cnt: 32'd0, pend: 1'b0, out_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign irq.busy         = ~s_r.out_n;
  assign host_interrupt_n = s_r.out_n;

endmodule : chgctl_irq_pulse

// >>> rtl/chgctl_top.sv
// chgctl_top: mode control (default/host, boost, pulse skip) and charge cycle
// assumes analog levels arrive as mV/mA words and comparator flags, synchronous to mclk
`timescale 1ns/1ns
module chgctl_top
  import chgctl_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire chgctl_pkg::chgctl_cfg_t host_cfg,
  input  wire logic                  host_keepalive_kick,
  input  wire logic                  reg_reset_kick,
  input  wire logic [3:0]            input_voltage_limit_code,
  input  wire logic [12:0]           input_voltage_limit,
  input  wire logic [1:0]            input_voltage_limit_offset,
  input  wire logic [12:0]           input_current_limit,
  input  wire logic                  battery_switch_delay,
  input  wire logic                  battery_switch_disable,
  input  wire logic [15:0]           topoff_cycles,
  input  wire logic                  charge_enable_pin_n,
  input  wire logic                  converter_ready,
  input  wire logic                  thermistor_fault,
  input  wire logic                  thermistor_boost_ok,
  input  wire logic                  safety_fault,
  input  wire logic                  input_regulating,
  input  wire logic                  thermal_regulating,
  input  wire logic                  supplement_needed,
  input  wire logic                  battery_above_boost_low,
  input  wire logic                  vbus_below_sleep,
  input  wire logic                  battery_below_sys_min,
  input  wire logic [12:0]           battery_mv,
  input  wire logic [12:0]           system_mv,
  input  wire logic [12:0]           charge_ma,
  output logic [12:0]                vin_limit_mv,
  output logic [12:0]                iin_limit_ma,
  output logic [12:0]                charge_target_ma,
  output logic [12:0]                charge_vreg_mv,
  output logic [12:0]                boost_limit_ma,
  output logic                       boost_active,
  output logic [2:0]                 input_source_status_code,
  output logic                       battery_switch,
  output logic                       pulse_skip_allow,
  output logic                       host_mode,
  output logic                       timeout_flag,
  output logic                       kept_switch_delay,
  output logic                       kept_switch_disable,
  output logic [1:0]                 charge_phase_code,
  output logic                       topoff_running_flag,
  output logic                       safety_half_rate,
  output logic                       indicator_out,
  output logic                       indicator_oe_n,
  output logic                       host_interrupt_n
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic          host;
    logic [31:0]   wd_cnt;
    logic [1:0]    wd_units;
    logic [31:0]   otg_cnt;
    logic          boost;
    chgctl_phase_t ph;
    logic [15:0]   top_cnt;
    logic [15:0]   top_set;
    logic          term_seen;
    logic          en_prev;
    logic [31:0]   blink_cnt;
    logic [1:0]    blink_sec;
    logic [12:0]   vin;
    logic [12:0]   iin;
    logic [12:0]   itgt;
    logic [12:0]   vreg;
    logic [12:0]   blim;
    logic [2:0]    src;
    logic          bsw;
    logic          pskip;
    logic [1:0]    code;
    logic          half;
    logic          ind;
    logic          dly;
    logic          dis;
  } chgctl_st_t;

  chgctl_st_t s_r, s_nxt;
  chgctl_cfg_t cfg;
  logic        irq_stb;
  chgctl_irq_if irq ();

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [12:0] chgctl_min(input logic [12:0] a, input logic [12:0] b);
    chgctl_min = (a < b) ? a : b;
  endfunction : chgctl_min

  function automatic logic [12:0] chgctl_track(input logic [1:0] sel);
    case (sel)
      2'h1:    chgctl_track = TRACK_OFS0_MV;
      2'h2:    chgctl_track = TRACK_OFS1_MV;
      default: chgctl_track = TRACK_OFS2_MV;
    endcase
  endfunction : chgctl_track

  // default mode forces the documented charge profile
  always_comb begin
    cfg = host_cfg;
    if (!s_r.host) begin
      cfg.vreg_mv  = DEF_VREG_MV;
      cfg.fast_charge_current_ma  = DEF_FAST_CHARGE_CURRENT_MA;
      cfg.ipre_ma  = DEF_IPRE_MA;
      cfg.iterm_ma = DEF_ITERM_MA;
      cfg.track_sel = 2'h0;
      cfg.rechg_sel = 1'b0;
      cfg.term_en   = 1'b1;
      cfg.chg_en    = 1'b1;
      cfg.pskip_dis = 1'b0;
      cfg.otg_en    = 1'b0;
      cfg.boost_hi  = 1'b1;
      cfg.mon_sel   = 2'h0;
      cfg.ovr_sel   = 2'h0;
      cfg.wd_sel    = DEF_WD_SEL;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic        chg_on;
  logic        regulating;
  logic [12:0] rechg_mv;
  logic [12:0] trk;
  logic        start_ok;
  logic        toggled;

  always_comb begin
    s_nxt   = s_r;
    irq_stb = 1'b0;
    chg_on   = cfg.chg_en && !charge_enable_pin_n && (cfg.fast_charge_current_ma != 13'd0);
    regulating = input_regulating || thermal_regulating;
    rechg_mv = cfg.vreg_mv - (cfg.rechg_sel ? RECHG1_MV : RECHG0_MV);
    trk      = 13'(battery_mv + chgctl_track(cfg.track_sel));
    start_ok = converter_ready && !thermistor_fault && !safety_fault && !battery_switch_disable
               && chg_on && (battery_mv < cfg.vreg_mv);
    toggled  = chg_on && !s_r.en_prev;
    s_nxt.en_prev = chg_on;

    // host timeout
    if (host_keepalive_kick) begin
      s_nxt.host     = 1'b1;
      s_nxt.wd_cnt   = 32'd0;
      s_nxt.wd_units = 2'h0;
    end else if (s_r.host && host_cfg.wd_sel != 2'h0) begin
      s_nxt.wd_cnt = s_r.wd_cnt + 32'd1;
      if (s_r.wd_cnt == WD_UNIT_CYC - 32'd1) begin
        s_nxt.wd_cnt   = 32'd0;
        s_nxt.wd_units = s_r.wd_units + 2'h1;
        if (s_r.wd_units == host_cfg.wd_sel - 2'h1) begin
          s_nxt.host = 1'b0;
        end
      end
    end

    // kept values follow the host inputs every cycle, in host and default mode alike
    s_nxt.dly = battery_switch_delay;
    s_nxt.dis = battery_switch_disable;

    // input limits
    s_nxt.vin = input_voltage_limit;
    if (cfg.track_sel != 2'h0 && input_voltage_limit_offset == 2'h0 && trk > input_voltage_limit) begin
      s_nxt.vin = trk;
    end
    s_nxt.iin = (system_mv < SYS_LOW_MV) ? chgctl_min(STARTUP_MA, input_current_limit)
                                         : input_current_limit;

    // boost entry
    if (!cfg.otg_en) begin
      s_nxt.otg_cnt = 32'd0;
      s_nxt.boost   = 1'b0;
    end else begin
      if (s_r.otg_cnt < OTG_WAIT_CYC) begin
        s_nxt.otg_cnt = s_r.otg_cnt + 32'd1;
      end
      s_nxt.boost = (s_r.otg_cnt >= OTG_WAIT_CYC) && battery_above_boost_low
                    && thermistor_boost_ok && (s_r.boost || vbus_below_sleep);
    end
    s_nxt.blim = cfg.boost_hi ? BOOST_HI_MA : BOOST_LO_MA;
    s_nxt.src  = s_nxt.boost ? SRC_BOOST : 3'h0;
    s_nxt.pskip = !cfg.pskip_dis && (s_r.boost || !chg_on || battery_below_sys_min);

    // charge cycle
    case (s_r.ph)
      CHGCTL_IDLE: begin
        if (start_ok) begin
          s_nxt.ph = CHGCTL_RUN;
        end
      end
      CHGCTL_RUN: begin
        if (!chg_on) begin
          s_nxt.ph = CHGCTL_IDLE;
        end else if (cfg.term_en && !regulating && battery_mv > rechg_mv && charge_ma < cfg.iterm_ma) begin
          s_nxt.top_set = topoff_cycles;
          s_nxt.top_cnt = 16'd0;
          if (topoff_cycles == 16'd0) begin
            s_nxt.ph = CHGCTL_DONE;
            irq_stb  = 1'b1;
          end else begin
            s_nxt.ph = CHGCTL_TOPOFF;
            irq_stb  = 1'b1;
          end
        end
      end
      CHGCTL_TOPOFF: begin
        if (!chg_on || reg_reset_kick) begin
          s_nxt.ph = chg_on ? CHGCTL_RUN : CHGCTL_IDLE;
        end else if (!thermistor_fault && !safety_fault && !supplement_needed
                     && (!regulating || !s_r.half)) begin
          s_nxt.top_cnt = s_r.top_cnt + 16'd1;
          if (s_r.top_cnt + 16'd1 >= s_r.top_set) begin
            s_nxt.ph = CHGCTL_DONE;
            irq_stb  = 1'b1;
          end
        end
      end
      CHGCTL_DONE: begin
        if (toggled || (chg_on && battery_mv < rechg_mv && start_ok)) begin
          s_nxt.ph = CHGCTL_RUN;
        end else if (!chg_on) begin
          s_nxt.ph = CHGCTL_IDLE;
        end
      end
      default: s_nxt.ph = CHGCTL_IDLE;
    endcase
    if (s_r.ph == CHGCTL_IDLE || s_r.ph == CHGCTL_DONE) begin
      s_nxt.half = 1'b0;
    end else begin
      s_nxt.half = regulating ? !s_r.half : 1'b0;
    end

    // charge current and phase code
    s_nxt.vreg = cfg.vreg_mv;
    s_nxt.itgt = 13'd0;
    s_nxt.code = PHASE_OFF;
    if (s_r.ph == CHGCTL_RUN || s_r.ph == CHGCTL_TOPOFF) begin
      if (battery_mv < SHORT_BAT_MV) begin
        s_nxt.itgt = DEF_ISHORT_MA;
        s_nxt.code = PHASE_PRE;
      end else if (battery_mv <= PRE_BAT_MV) begin
        s_nxt.itgt = cfg.ipre_ma;
        s_nxt.code = PHASE_PRE;
      end else begin
        s_nxt.itgt = cfg.fast_charge_current_ma;
        s_nxt.code = PHASE_FAST;
      end
    end else if (s_r.ph == CHGCTL_DONE) begin
      s_nxt.code = PHASE_DONE;
    end

    // battery switch
    s_nxt.bsw = converter_ready && !battery_switch_disable && chg_on
                && (s_r.ph != CHGCTL_DONE || supplement_needed);
    if (!converter_ready || s_r.ph == CHGCTL_DONE) begin
      s_nxt.bsw = s_nxt.bsw || supplement_needed;
    end

    // indicator blink timebase, one step per second
    s_nxt.blink_cnt = s_r.blink_cnt + 32'd1;
    if (s_r.blink_cnt == BLINK_CYC - 32'd1) begin
      s_nxt.blink_cnt = 32'd0;
      s_nxt.blink_sec = s_r.blink_sec + 2'h1;
    end
    if (cfg.mon_sel == MON_OFF) begin
      s_nxt.ind = 1'b0;
    end else if (cfg.mon_sel == MON_OVRD) begin
      case (cfg.ovr_sel)
        OVR_OFF:     s_nxt.ind = 1'b0;
        OVR_LOW:     s_nxt.ind = 1'b1;
        OVR_BLINK11: s_nxt.ind = !s_r.blink_sec[0];
        OVR_BLINK13: s_nxt.ind = (s_r.blink_sec == 2'h0);
        default:     s_nxt.ind = 1'b0;
      endcase
    end else if (thermistor_fault || safety_fault) begin
      s_nxt.ind = !s_r.blink_sec[0];
    end else begin
      s_nxt.ind = (s_r.ph == CHGCTL_RUN || s_r.ph == CHGCTL_TOPOFF);
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign irq.event_stb = irq_stb;

  chgctl_irq_pulse u_irq (
    .mclk             (mclk),
    .rst              (rst),
    .irq              (irq),
    .host_interrupt_n (host_interrupt_n)
  );

  // ------------------------------------------------------------
  // outputs from flip-flops, some through an inverter or a state decode; indicator_out is tied low
  // ------------------------------------------------------------
  assign vin_limit_mv             = s_r.vin;
  assign iin_limit_ma             = s_r.iin;
  assign charge_target_ma         = s_r.itgt;
  assign charge_vreg_mv           = s_r.vreg;
  assign boost_limit_ma           = s_r.blim;
  assign boost_active             = s_r.boost;
  assign input_source_status_code = s_r.src;
  assign battery_switch           = s_r.bsw;
  assign pulse_skip_allow         = s_r.pskip;
  assign host_mode                = s_r.host;
  assign timeout_flag             = ~s_r.host;
  assign kept_switch_delay        = s_r.dly;
  assign kept_switch_disable      = s_r.dis;
  assign charge_phase_code        = s_r.code;
  assign topoff_running_flag      = (s_r.ph == CHGCTL_TOPOFF);
  assign safety_half_rate         = s_r.half;
  assign indicator_out            = 1'b0;
  assign indicator_oe_n           = ~s_r.ind;

endmodule : chgctl_top

// >>> verif/chgctl_host_model.sv
// chgctl_host_model: host side that writes the keepalive and counts interrupt pulses
// assumes the bench raises kick_req once for each keepalive write it wants
`timescale 1ns/1ns
module chgctl_host_model (
  input  wire logic  mclk,
  input  wire logic  rst,
  input  wire logic  kick_req,
  input  wire logic  host_interrupt_n,
  output logic       host_keepalive_kick,
  output logic [7:0] irq_count
);
  logic req_r;
  logic int_r;
  // ----------------------------------------
  // keepalive writes and interrupt count
  // ----------------------------------------
  // one write per request edge, so a held request never reads as repeated writes
  assign host_keepalive_kick = kick_req & ~req_r;
  always_ff @(posedge mclk) begin
    req_r <= kick_req;
    int_r <= host_interrupt_n;
    if (rst) begin
      irq_count <= 8'h0;
    end else if (int_r && !host_interrupt_n) begin
      irq_count <= irq_count + 8'h1;
    end
  end
endmodule : chgctl_host_model

// >>> verif/chgctl_top_assertions.sv
// chgctl_top_assertions: port-level checks of the charge control top
// assumes it is bound to chgctl_top and sees only that module's ports
`timescale 1ns/1ns
module chgctl_top_assertions (
  input wire logic                    mclk,
  input wire logic                    rst,
  input wire chgctl_pkg::chgctl_cfg_t host_cfg,
  input wire logic                    host_keepalive_kick,
  input wire logic [12:0]             input_current_limit,
  input wire logic [12:0]             system_mv,
  input wire logic [12:0]             iin_limit_ma,
  input wire logic [12:0]             charge_vreg_mv,
  input wire logic                    boost_active,
  input wire logic [2:0]              input_source_status_code,
  input wire logic                    host_mode,
  input wire logic                    timeout_flag,
  input wire logic [1:0]              charge_phase_code,
  input wire logic                    indicator_oe_n,
  input wire logic                    host_interrupt_n
);
  import chgctl_pkg::*;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [15:0] low_cnt_r;
  logic [15:0] low_cnt_nxt;
  logic [12:0] clamp_exp;
  // counts low samples of the interrupt line; cleared by reset so a cut pulse is not judged
  always_comb begin
    low_cnt_nxt = host_interrupt_n ? 16'h0 : low_cnt_r + 16'h1;
    clamp_exp = (input_current_limit < STARTUP_MA) ? input_current_limit : STARTUP_MA;
  end
  always_ff @(posedge mclk) begin
    low_cnt_r <= rst ? 16'h0 : low_cnt_nxt;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_flag_mode: assert property (timeout_flag != host_mode)
    else $error("timeout flag disagrees with mode");
  a_kick_host: assert property (host_keepalive_kick |=> host_mode && !timeout_flag)
    else $error("keepalive did not enter host mode");
  a_int_width: assert property (!$past(rst) && $rose(host_interrupt_n) |-> low_cnt_r == INT_PULSE_CYC)
    else $error("interrupt pulse width wrong");
  a_done_pulse: assert property ($rose(charge_phase_code == PHASE_DONE) |-> ##[0:2] !host_interrupt_n)
    else $error("no interrupt on completion");
  a_boost_status: assert property (input_source_status_code == (boost_active ? SRC_BOOST : 3'h0))
    else $error("source status wrong for boost state");
  a_input_clamp: assert property (!rst && system_mv < SYS_LOW_MV |=> iin_limit_ma == $past(clamp_exp))
    else $error("start-up current clamp wrong");
  a_default_vreg: assert property (!rst && !host_mode ##1 !host_mode |-> charge_vreg_mv == DEF_VREG_MV)
    else $error("default regulation voltage wrong");
  a_mon_off: assert property (host_mode && host_cfg.mon_sel == MON_OFF ##1 host_mode |-> indicator_oe_n)
    else $error("indicator driven while disabled");
  c_kick: cover property (host_keepalive_kick);
  c_done: cover property ($rose(charge_phase_code == PHASE_DONE));
  c_ind_low: cover property (host_mode && !indicator_oe_n);
endmodule : chgctl_top_assertions

bind chgctl_top chgctl_top_assertions i_chk (.mclk, .rst, .host_cfg, .host_keepalive_kick, .input_current_limit,
  .system_mv, .iin_limit_ma, .charge_vreg_mv, .boost_active, .input_source_status_code, .host_mode,
  .timeout_flag, .charge_phase_code, .indicator_oe_n, .host_interrupt_n);

// >>> verif/tb_top.sv
// tb_top: self-checking bench of the charge control top
// assumes package defaults; boost entry and watchdog expiry are too long for this run
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import chgctl_pkg::*;
  typedef struct packed {logic [12:0] bat, sys, ilim, tgt, iin; logic [1:0] code;} chgctl_row_t;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        kick_req = 1'b0, reg_reset_kick = 1'b0, battery_switch_delay = 1'b0, input_regulating = 1'b0;
  logic        thermal_regulating = 1'b0, supplement_needed = 1'b0, battery_below_sys_min = 1'b0, h;
  logic [4:0]  blk = 5'h0;
  logic [1:0]  input_voltage_limit_offset = 2'h0;
  logic [12:0] input_voltage_limit = 13'h1194, input_current_limit = 13'h1F4;
  logic [12:0] battery_mv = 13'hFA0, system_mv = 13'hED8, charge_ma = 13'h3E8;
  chgctl_cfg_t host_cfg = '0;
  logic        host_keepalive_kick, thermistor_fault, safety_fault, battery_switch_disable;
  logic        charge_enable_pin_n, converter_ready, boost_active, battery_switch, pulse_skip_allow;
  logic        host_mode, timeout_flag, kept_switch_delay, kept_switch_disable, topoff_running_flag;
  logic        safety_half_rate, indicator_out, indicator_oe_n, host_interrupt_n;
  logic [12:0] vin_limit_mv, iin_limit_ma, charge_target_ma, charge_vreg_mv, boost_limit_ma;
  logic [2:0]  input_source_status_code;
  logic [1:0]  charge_phase_code;
  logic [7:0]  irq_count;
  int          error_cnt = 0, num_checks = 0, cyc_cnt = 0, n;
  chgctl_row_t rows [4] = '{'{13'h7D0, 13'hED8, 13'h1F4, DEF_ISHORT_MA, 13'h1F4, PHASE_PRE},
                            '{13'hBB8, 13'h7D0, 13'h1F4, DEF_IPRE_MA, STARTUP_MA, PHASE_PRE},
                            '{13'hBB8, 13'h7D0, 13'h096, DEF_IPRE_MA, 13'h096, PHASE_PRE},
                            '{13'hFA0, 13'hED8, 13'h1F4, DEF_FAST_CHARGE_CURRENT_MA, 13'h1F4, PHASE_FAST}};
  // one bit per start condition; the top bit blocks by pulling converter_ready low
  assign {converter_ready, charge_enable_pin_n, battery_switch_disable, safety_fault, thermistor_fault} = blk ^ 5'h10;
  chgctl_top i_dut (.mclk, .rst, .host_cfg, .host_keepalive_kick, .reg_reset_kick, .input_voltage_limit_code(4'h0),
    .input_voltage_limit, .input_voltage_limit_offset, .input_current_limit, .battery_switch_delay,
    .battery_switch_disable, .topoff_cycles(16'h0), .charge_enable_pin_n, .converter_ready, .thermistor_fault,
    .thermistor_boost_ok(1'b1), .safety_fault, .input_regulating, .thermal_regulating, .supplement_needed,
    .battery_above_boost_low(1'b1), .vbus_below_sleep(1'b1), .battery_below_sys_min, .battery_mv, .system_mv,
    .charge_ma, .vin_limit_mv, .iin_limit_ma, .charge_target_ma, .charge_vreg_mv, .boost_limit_ma, .boost_active,
    .input_source_status_code, .battery_switch, .pulse_skip_allow, .host_mode, .timeout_flag, .kept_switch_delay,
    .kept_switch_disable, .charge_phase_code, .topoff_running_flag, .safety_half_rate, .indicator_out,
    .indicator_oe_n, .host_interrupt_n);
  chgctl_host_model i_host (.mclk, .rst, .kick_req, .host_interrupt_n, .host_keepalive_kick, .irq_count);
  // ----------------------------------------
  // clock, tasks, timeout
  // ----------------------------------------
  initial forever #4 mclk = ~mclk;
  task automatic tick(int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : tick
  task automatic done(string s);
    $display("test %s finished", s);
  endtask : done
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // the run needs about 32k cycles, mostly the one full interrupt pulse
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    `CHK(host_mode, 1'b0)
    `CHK(timeout_flag, 1'b1)
    done("reset");
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      rst <= 1'b1;
      blk[i] <= 1'b1;
      tick(2);
      @(posedge mclk);
      rst <= 1'b0;
      tick(4);
      `CHK(charge_phase_code, PHASE_OFF)
      @(posedge mclk);
      blk <= 5'h0;
      tick(4);
      `CHK(charge_phase_code, PHASE_FAST)
    end
    done("start");
    foreach (rows[i]) begin
      @(posedge mclk);
      battery_mv <= rows[i].bat;
      system_mv <= rows[i].sys;
      input_current_limit <= rows[i].ilim;
      tick(4);
      `CHK(charge_target_ma, rows[i].tgt)
      `CHK(charge_phase_code, rows[i].code)
      `CHK(iin_limit_ma, rows[i].iin)
      `CHK(charge_vreg_mv, DEF_VREG_MV)
      `CHK(indicator_oe_n, 1'b0)
    end
    done("rows");
    @(posedge mclk);
    battery_mv <= 13'h1036;
    charge_ma <= 13'h064;
    input_regulating <= 1'b1;
    thermal_regulating <= 1'b1;
    tick(6);
    `CHK(charge_phase_code, PHASE_FAST)
    h = safety_half_rate;
    tick(1);
    `CHK(safety_half_rate, ~h)
    @(posedge mclk);
    input_regulating <= 1'b0;
    thermal_regulating <= 1'b0;
    tick(1);
    for (n = 0; n < 10 && charge_phase_code !== PHASE_DONE; n++) tick(1);
    `CHK(charge_phase_code, PHASE_DONE)
    for (n = 0; n < 3 && host_interrupt_n !== 1'b0; n++) tick(1);
    `CHK(host_interrupt_n, 1'b0)
    `CHK(battery_switch, 1'b0)
    `CHK(indicator_oe_n, 1'b1)
    for (n = 0; n < 33000 && host_interrupt_n !== 1'b1; n++) tick(1);
    `CHK(n, INT_PULSE_CYC)
    @(posedge mclk);
    supplement_needed <= 1'b1;
    tick(3);
    `CHK(battery_switch, 1'b1)
    `CHK(irq_count, 8'h1)
    @(posedge mclk);
    supplement_needed <= 1'b0;
    battery_mv <= 13'hFA0;
    charge_ma <= 13'h3E8;
    tick(4);
    `CHK(charge_phase_code, PHASE_FAST)
    done("termination");
    @(posedge mclk);
    kick_req <= 1'b1;
    tick(2);
    `CHK(host_mode, 1'b1)
    `CHK(timeout_flag, 1'b0)
    @(posedge mclk);
    host_cfg <= '{13'h10FE, 13'h3E8, 13'h096, 13'h078, 2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0,
                  MON_OVRD, OVR_LOW, 2'h0};
    input_voltage_limit <= 13'h1004;
    battery_switch_delay <= 1'b1;
    tick(3);
    `CHK(vin_limit_mv, 13'h1068)
    `CHK(charge_vreg_mv, 13'h10FE)
    `CHK(indicator_oe_n, 1'b0)
    `CHK(kept_switch_delay, 1'b1)
    @(posedge mclk);
    input_voltage_limit_offset <= 2'h1;
    host_cfg.ovr_sel <= OVR_OFF;
    tick(3);
    `CHK(vin_limit_mv, 13'h1004)
    `CHK(indicator_oe_n, 1'b1)
    @(posedge mclk);
    host_cfg.mon_sel <= MON_OFF;
    host_cfg.ovr_sel <= OVR_LOW;
    tick(3);
    `CHK(indicator_oe_n, 1'b1)
    done("host");
    @(posedge mclk);
    host_cfg.chg_en <= 1'b0;
    reg_reset_kick <= 1'b1;
    tick(3);
    `CHK(charge_phase_code, PHASE_OFF)
    `CHK(battery_switch, 1'b0)
    `CHK(pulse_skip_allow, 1'b1)
    @(posedge mclk);
    reg_reset_kick <= 1'b0;
    host_cfg.pskip_dis <= 1'b1;
    tick(3);
    `CHK(pulse_skip_allow, 1'b0)
    @(posedge mclk);
    host_cfg.chg_en <= 1'b1;
    host_cfg.pskip_dis <= 1'b0;
    battery_below_sys_min <= 1'b1;
    tick(3);
    `CHK(pulse_skip_allow, 1'b1)
    `CHK(battery_switch, 1'b1)
    done("switching");
    tally_and_finish();
  end
endmodule : tb_top
